// >>> dress_sup_pkg.sv
// types shared by the dressing supervisor
`default_nettype none
package dress_sup_pkg;

   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_run = 2'b01,
      st_halt = 2'b11,
      st_wait_ack = 2'b10
   } sup_state_t;

   typedef struct packed {
      logic [6:0] num;
      logic [9:0] spots;
      logic [5:0] ramp_pct;
      logic [4:0] offs_pct;
      logic [5:0] dress_alarm;
      logic [5:0] life_alarm;
      logic [15:0] base_cur;
   } dress_cfg_t;

   typedef struct packed {
      logic dress_warn;
      logic life_warn;
      logic halted;
   } dress_out_t;

endpackage
`default_nettype wire

// >>> dress_sup_regs.svh
// register offsets, field positions, reset values, interrupt bits and fault codes for the dressing supervisor
`ifndef DRESS_SUP_REGS_SVH
`define DRESS_SUP_REGS_SVH

`define DS_OFF_CTRL 8'h00
`define DS_OFF_CFG0 8'h04
`define DS_OFF_CFG1 8'h08
`define DS_OFF_STATUS 8'h0C
`define DS_OFF_IRQ_STAT 8'h10
`define DS_OFF_IRQ_MASK 8'h14
`define DS_OFF_CURRENT 8'h18
`define DS_OFF_COUNT 8'h1C

// cfg0 fields
`define DS_F_NUM_LSB 0
`define DS_F_SPOTS_LSB 8
`define DS_F_RAMP_LSB 20
`define DS_F_OFFS_LSB 26
// cfg1 fields
`define DS_F_DALARM_LSB 0
`define DS_F_EALARM_LSB 8
`define DS_F_BASE_LSB 16

`define DS_RST_CFG0 32'h0000_0000
`define DS_RST_CFG1 32'h0000_0000

// interrupt status bits
`define DS_IRQ_DWARN 0
`define DS_IRQ_EWARN 1
`define DS_IRQ_HALT 2
`define DS_IRQ_NEXT 3

`define DS_ERR_DRESS 16'h0116
`define DS_ERR_LIFE 16'h0117

`endif

// >>> dresser_station.sv
// behavioural dresser station and machine controller facing the supervisor
`timescale 1ns/1ps
`default_nettype none
`include "dress_sup_regs.svh"
module dresser_station #(
   parameter int LAT = 4
)
(
   // clock, reset and bench control
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ack_en,
   // supervisor outputs
   input wire logic dress_warn,
   input wire logic life_warn,
   input wire logic weld_halt,
   input wire logic [15:0] fault_code,
   // acknowledges back
   output logic dress_ack,
   output logic replace_ack,
   output logic fault_ack
);
   logic life_q;
   // one process owns all three acknowledges; outputs are read at the falling
   // edge so the answer never races the clock
   initial
   begin
      {dress_ack, replace_ack, fault_ack} = 3'b000;
      forever
      begin
         @(negedge clk);
         if (rst_b && ack_en && (weld_halt || dress_warn || life_warn))
         begin
            life_q = weld_halt ? (fault_code == `DS_ERR_LIFE) : life_warn;
            if (weld_halt)
            begin
               @(posedge clk);
               fault_ack <= 1'b1;
               @(posedge clk);
               fault_ack <= 1'b0;
            end
            repeat (LAT) @(posedge clk);
            replace_ack <= life_q;
            dress_ack <= !life_q;
            @(posedge clk);
            {replace_ack, dress_ack} <= 2'b00;
         end
      end
   end
endmodule
`default_nettype wire

// >>> electrode_dressing_supervisor.sv
// electrode tip dressing supervisor with axi4-lite register access
`timescale 1ns/1ps
`default_nettype none
`include "dress_sup_regs.svh"
// Overview of operation
// (RL1) The first interval starts at the base current, each later one at base plus the offset.
// (RL2) The dressing warning drops as soon as the dressing acknowledge comes in.
// (RL3) Reaching an interval's last spot with the warning still up halts welding with fault 116.
// (RL4) Recovery needs the fault acknowledge first and only then the alarm acknowledge.
// (RL5) The end-of-life warning clears, halts and recovers in the same way as the dressing warning.
// (RL6) The electrode-replaced acknowledge returns the spot counter to zero.
// (RL7) Within an interval the current rises so the ramp percentage is reached at its last spot.
// (RL8) The dressing warning is raised over the notice spots at the end of each interval except the last, which raises the end-of-life warning.
// (RL9) A dressing count of zero disables warnings, halts and current stepping.
// (RL10) Any write to a dressing parameter clears the counter and restarts from interval one.
// (RL11) Each weld spot advances the counter, and each full interval moves to the next one.
module electrode_dressing_supervisor
   import dress_sup_pkg::*;
#(
   parameter int CUR_W = 16
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // weld process
   input wire logic spot_done,
   output logic weld_halt,
   output logic [CUR_W-1:0] weld_current,
   output logic [15:0] fault_code,
   // dresser and machine controller
   input wire logic dress_ack,
   input wire logic replace_ack,
   input wire logic fault_ack,
   output logic dress_warn,
   output logic life_warn,
   output logic irq,
   // axi4-lite slave
   input wire logic [7:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [7:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready
);

   logic rst_s1_q, rst_n;
   // reset released through two flops so all logic leaves reset on one edge
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rst_s1_q <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_s1_q <= 1'b1;
         rst_n <= rst_s1_q;
      end
   end

   // byte-lane merge, used by both config registers
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (be[i])
            r[i*8 +: 8] = nw[i*8 +: 8];
      return r;
   endfunction

   logic [31:0] cfg0_q, cfg1_q, wdata_q;
   logic [3:0] irq_stat_q, irq_mask_q, wstrb_q;
   logic [7:0] awaddr_q;
   logic aw_held_q, w_held_q, wr_fire, cfg_wr;
   dress_cfg_t cfg;
   assign cfg.num = cfg0_q[`DS_F_NUM_LSB +: 7];
   assign cfg.spots = cfg0_q[`DS_F_SPOTS_LSB +: 10];
   assign cfg.ramp_pct = cfg0_q[`DS_F_RAMP_LSB +: 6];
   assign cfg.offs_pct = cfg0_q[`DS_F_OFFS_LSB +: 5];
   assign cfg.dress_alarm = cfg1_q[`DS_F_DALARM_LSB +: 6];
   assign cfg.life_alarm = cfg1_q[`DS_F_EALARM_LSB +: 6];
   assign cfg.base_cur = cfg1_q[`DS_F_BASE_LSB +: 16];

   // write address and data are latched independently, in either order
   assign s_awready = !aw_held_q && !s_bvalid;
   assign s_wready = !w_held_q && !s_bvalid;
   assign wr_fire = aw_held_q && w_held_q && !s_bvalid;
   assign cfg_wr = wr_fire && (awaddr_q == `DS_OFF_CFG0 || awaddr_q == `DS_OFF_CFG1);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         s_bvalid <= 1'b0;
         s_bresp <= 2'b00;
      end
      else
      begin
         if (s_awvalid && s_awready)
         begin
            aw_held_q <= 1'b1;
            awaddr_q <= s_awaddr;
         end
         if (s_wvalid && s_wready)
         begin
            w_held_q <= 1'b1;
            wdata_q <= s_wdata;
            wstrb_q <= s_wstrb;
         end
         if (wr_fire)
         begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            s_bvalid <= 1'b1;
            s_bresp <= (awaddr_q > `DS_OFF_IRQ_MASK || awaddr_q[1:0] != 2'b00) ? 2'b10 : 2'b00;
         end
         else if (s_bvalid && s_bready)
            s_bvalid <= 1'b0;
      end
   end

   // config registers; any write to them restarts the schedule
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg0_q <= `DS_RST_CFG0;
         cfg1_q <= `DS_RST_CFG1;
         irq_mask_q <= 4'h0;
      end
      else if (wr_fire)
      begin
         if (awaddr_q == `DS_OFF_CFG0)
            cfg0_q <= merge(cfg0_q, wdata_q, wstrb_q);
         if (awaddr_q == `DS_OFF_CFG1)
            cfg1_q <= merge(cfg1_q, wdata_q, wstrb_q);
         if (awaddr_q == `DS_OFF_IRQ_MASK && wstrb_q[0])
            irq_mask_q <= wdata_q[3:0];
      end
   end

   // supervisor state
   sup_state_t state_q;
   logic [9:0] spot_q, spots_left;
   logic [6:0] intv_q;
   logic last_spot, life_interval, dress_ev, life_ev, halt_ev, next_ev, enabled;
   assign enabled = cfg.num != 7'd0; // RL9
   assign spots_left = cfg.spots - spot_q;
   assign last_spot = spot_q == cfg.spots - 10'd1;
   assign life_interval = intv_q == cfg.num - 7'd1;
   // each warning rises once per interval, so an acknowledged one stays down; set wins
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dress_warn <= 1'b0;
         life_warn <= 1'b0;
      end
      else if (cfg_wr || !enabled)
      begin
         dress_warn <= 1'b0;
         life_warn <= 1'b0;
      end
      else
      begin
         if (dress_ev)
            dress_warn <= 1'b1; // RL8
         else if (dress_ack && state_q != st_halt)
            dress_warn <= 1'b0; // RL2 RL4
         if (life_ev)
            life_warn <= 1'b1; // RL5
         else if (replace_ack && state_q != st_halt)
            life_warn <= 1'b0; // RL5 RL4
      end
   end

   assign dress_ev = spot_done && state_q == st_run && enabled && !dress_warn && !life_interval
                     && spots_left - 10'd1 == {4'd0, cfg.dress_alarm} && cfg.dress_alarm != 6'd0;
   assign life_ev = spot_done && state_q == st_run && enabled && !life_warn && life_interval
                    && spots_left - 10'd1 == {4'd0, cfg.life_alarm} && cfg.life_alarm != 6'd0;
   assign halt_ev = spot_done && state_q == st_run && enabled && last_spot
                    && (dress_warn || life_warn) && !dress_ack && !replace_ack;
   assign next_ev = spot_done && state_q == st_run && enabled && last_spot && !halt_ev;

   // counter, interval index and halt sequence
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= st_idle;
         spot_q <= 10'd0;
         intv_q <= 7'd0;
         fault_code <= 16'h0000;
      end
      else if (cfg_wr)
      begin
         state_q <= st_idle; // RL10
         spot_q <= 10'd0;
         intv_q <= 7'd0;
         fault_code <= 16'h0000;
      end
      else
      begin
         unique case (state_q)
            st_idle:
               if (enabled && cfg.spots != 10'd0)
                  state_q <= st_run;
            st_run:
            begin
               if (!enabled)
                  state_q <= st_idle;
               else if (halt_ev)
               begin
                  state_q <= st_halt; // RL3
                  fault_code <= life_warn ? `DS_ERR_LIFE : `DS_ERR_DRESS;
               end
               else if (replace_ack)
               begin
                  spot_q <= 10'd0; // RL6
                  intv_q <= 7'd0;
               end
               else if (next_ev)
               begin
                  spot_q <= 10'd0; // RL11
                  intv_q <= life_interval ? 7'd0 : intv_q + 7'd1;
               end
               else if (spot_done)
                  spot_q <= spot_q + 10'd1; // RL11
            end
            st_halt:
               if (fault_ack)
               begin
                  state_q <= st_wait_ack; // RL4
                  fault_code <= 16'h0000;
               end
            st_wait_ack:
               if ((dress_ack && dress_warn) || (replace_ack && life_warn))
               begin
                  state_q <= st_run; // RL4
                  spot_q <= 10'd0;
                  intv_q <= replace_ack || life_interval ? 7'd0 : intv_q + 7'd1; // RL6
               end
         endcase
      end
   end

   assign weld_halt = state_q == st_halt || state_q == st_wait_ack; // RL3
   // current: base, plus offset after the first interval, plus linear ramp
   logic [CUR_W+7:0] start_cur;
   logic [CUR_W+17:0] ramp_num;
   logic [CUR_W-1:0] ramp_add;
   always_comb
   begin
      start_cur = {8'd0, cfg.base_cur};
      if (intv_q != 7'd0)
         start_cur = start_cur + (({8'd0, cfg.base_cur} * {19'd0, cfg.offs_pct}) / 24'd100); // RL1
      ramp_num = {10'd0, start_cur} * {28'd0, cfg.ramp_pct} * {24'd0, spot_q}; // RL7
      ramp_add = (cfg.spots > 10'd1)
                 ? CUR_W'(ramp_num / ({24'd0, cfg.spots - 10'd1} * 34'd100)) : '0;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         weld_current <= '0;
      else if (!enabled)
         weld_current <= CUR_W'(cfg.base_cur); // RL9
      else
         weld_current <= CUR_W'(start_cur) + ramp_add; // RL7
   end
   // sticky events: set wins over a write-one clear in the same cycle
   logic [3:0] ev_vec;
   assign ev_vec = {next_ev, halt_ev, life_ev, dress_ev};
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         irq_stat_q <= 4'h0;
      else if (wr_fire && awaddr_q == `DS_OFF_IRQ_STAT && wstrb_q[0])
         irq_stat_q <= (irq_stat_q & ~wdata_q[3:0]) | ev_vec;
      else
         irq_stat_q <= irq_stat_q | ev_vec;
   end
   assign irq = |(irq_stat_q & irq_mask_q);
   // read channel, one cycle latency
   assign s_arready = !s_rvalid;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_rvalid <= 1'b0;
         s_rdata <= 32'h0000_0000;
         s_rresp <= 2'b00;
      end
      else if (s_arvalid && s_arready)
      begin
         s_rvalid <= 1'b1;
         s_rresp <= 2'b00;
         unique case (s_araddr)
            `DS_OFF_CTRL: s_rdata <= {16'd0, fault_code};
            `DS_OFF_CFG0: s_rdata <= cfg0_q;
            `DS_OFF_CFG1: s_rdata <= cfg1_q;
            `DS_OFF_STATUS: s_rdata <= {27'd0, state_q, weld_halt, life_warn, dress_warn};
            `DS_OFF_IRQ_STAT: s_rdata <= {28'd0, irq_stat_q};
            `DS_OFF_IRQ_MASK: s_rdata <= {28'd0, irq_mask_q};
            `DS_OFF_CURRENT: s_rdata <= 32'(weld_current);
            `DS_OFF_COUNT: s_rdata <= {9'd0, intv_q, 6'd0, spot_q};
            default:
            begin
               s_rdata <= 32'h0000_0000;
               s_rresp <= 2'b10;
            end
         endcase
      end
      else if (s_rvalid && s_rready)
         s_rvalid <= 1'b0;
   end

endmodule
`default_nettype wire

// >>> electrode_dressing_supervisor_asserts.sv
// port-level assertions for the dressing supervisor
`timescale 1ns/1ps
`default_nettype none
module electrode_dressing_supervisor_asserts
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // weld and discrete i/o
   input wire logic spot_done,
   input wire logic weld_halt,
   input wire logic [15:0] fault_code,
   input wire logic dress_ack,
   input wire logic replace_ack,
   input wire logic fault_ack,
   input wire logic dress_warn,
   input wire logic life_warn
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // halts and dressing warnings only rise on a counted spot
   a_halt_on_spot: assert property ($rose(weld_halt) |-> $past(spot_done))
      else $error("halt entered without a spot");
   a_warn_on_spot: assert property ($rose(dress_warn) |-> $past(spot_done))
      else $error("warning raised without a spot");
   a_halt_code: assert property ($rose(weld_halt) |-> fault_code inside {16'h0116, 16'h0117})
      else $error("halt with wrong fault code");
   a_code_halts: assert property (fault_code != 16'h0000 |-> weld_halt)
      else $error("fault code shown while running");
   // outside a halt, acknowledges drop the matching warning on the next edge
   a_warn_clear: assert property (dress_warn && dress_ack && !weld_halt |=> !dress_warn)
      else $error("dressing warning survived its ack");
   a_life_clear: assert property (life_warn && replace_ack && !weld_halt |=> !life_warn)
      else $error("life warning survived its ack");
   // alarm acks before the fault reset must not release the halt
   a_fault_first: assert property (fault_code != 16'h0000 && !fault_ack |=> weld_halt)
      else $error("halt left without fault reset");
   a_halt_holds: assert property (weld_halt && !(fault_ack || dress_ack || replace_ack)
      |=> weld_halt)
      else $error("halt dropped with no acknowledge");
endmodule
`default_nettype wire

// >>> electrode_dressing_supervisor_tb_top.sv
// self-checking bench for the dressing supervisor
`timescale 1ns/1ps
`default_nettype none
`include "dress_sup_regs.svh"
module electrode_dressing_supervisor_tb_top;
   localparam int BASE = 1000;
   localparam int OFFS = 5;
   localparam int RAMP = 10;
   localparam logic [31:0] CFG0 = 32'h14A0_0A02; // 2 intervals of 10 spots
   localparam logic [31:0] CFG1 = 32'h03E8_0303; // base 1000, alarms 3 spots
   logic clk, rst_b, spot_done, ack_en, dress_ack, replace_ack, fault_ack;
   logic weld_halt, dress_warn, life_warn, irq, s_awvalid, s_awready, s_wvalid;
   logic s_wready, s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
   logic [15:0] weld_current, fault_code;
   logic [7:0] s_awaddr, s_araddr;
   logic [31:0] s_wdata, s_rdata, rv;
   logic [3:0] s_wstrb;
   logic [1:0] s_bresp, s_rresp, rr;
   int mismatches, n_checks;
   electrode_dressing_supervisor DUT (.*);
   dresser_station partner (.*);
   // 250 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic hang();
      mismatches++;
      conclude();
   endtask
   // bus outputs are read at the falling edge, equal to what the next rise samples
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, tb;
      @(posedge clk);
      {s_awaddr, s_wdata} <= {a, d};
      {s_awvalid, s_wvalid, s_bready} <= 3'b111;
      tb = 1'b0;
      for (int n = 0; n < 40 && !tb; n++)
      begin
         @(negedge clk);
         ta = s_awvalid && s_awready;
         tw = s_wvalid && s_wready;
         {tb, rr} = {s_bvalid, s_bresp};
         @(posedge clk);
         if (ta) s_awvalid <= 1'b0;
         if (tw) s_wvalid <= 1'b0;
      end
      s_bready <= 1'b0;
      if (!tb) hang();
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic ta, tr;
      @(posedge clk);
      s_araddr <= a;
      {s_arvalid, s_rready} <= 2'b11;
      tr = 1'b0;
      for (int n = 0; n < 40 && !tr; n++)
      begin
         @(negedge clk);
         ta = s_arvalid && s_arready;
         tr = s_rvalid;
         {rv, rr} = {s_rdata, s_rresp};
         @(posedge clk);
         if (ta) s_arvalid <= 1'b0;
      end
      s_rready <= 1'b0;
      if (!tr) hang();
      check(what, rv, exp);
   endtask
   // one-cycle spot pulses, five cycles apart
   task automatic spots(input int k);
      repeat (k)
      begin
         @(posedge clk);
         spot_done <= 1'b1;
         @(posedge clk);
         spot_done <= 1'b0;
         repeat (3) @(posedge clk);
      end
      @(negedge clk);
   endtask
   task automatic recover();
      @(posedge clk);
      ack_en <= 1'b1;
      for (int n = 0; n < 60 && weld_halt; n++)
         @(negedge clk);
      if (weld_halt) hang();
   endtask
   initial
   begin
      {rst_b, spot_done, ack_en, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
      {s_awaddr, s_araddr, s_wdata} = '0;
      s_wstrb = 4'hF;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      rdc(`DS_OFF_CFG0, `DS_RST_CFG0, "cfg0 reset");
      rdc(8'h40, 32'h0, "unmapped data");
      check("unmapped resp", rr, 2'b10);
      wr(`DS_OFF_COUNT, 32'h0000_0000);
      check("read-only write resp", rr, 2'b10);
      wr(`DS_OFF_IRQ_MASK, 32'h0000_0001);
      check("mask write resp", rr, 2'b00);
      wr(`DS_OFF_CFG1, CFG1);
      wr(`DS_OFF_CFG0, CFG0);
      ack_en <= 1'b1;
      @(negedge clk);
      check("start current", weld_current, BASE);
      spots(6);
      check("warn early", dress_warn, 1'b0);
      spots(1);
      check("warn at notice", dress_warn, 1'b1);
      check("irq on warn", irq, 1'b1);
      spots(1);
      check("warn after ack", dress_warn, 1'b0);
      spots(1);
      check("ramp top", weld_current, BASE * (100 + RAMP) / 100);
      check("warn stays acked", dress_warn, 1'b0);
      wr(`DS_OFF_IRQ_STAT, 32'h0000_000F);
      @(negedge clk);
      check("irq cleared", irq, 1'b0);
      spots(1);
      check("offset start", weld_current, BASE * (100 + OFFS) / 100);
      rdc(`DS_OFF_COUNT, 32'h0001_0000, "next interval");
      spots(7);
      check("life warn", life_warn, 1'b1);
      // partner answers four edges after the warning
      repeat (3) @(negedge clk);
      check("life after ack", life_warn, 1'b0);
      rdc(`DS_OFF_COUNT, 32'h0, "count after replace");
      spots(2);
      wr(`DS_OFF_CFG0, CFG0);
      rdc(`DS_OFF_COUNT, 32'h0, "count after cfg");
      ack_en <= 1'b0;
      spots(10);
      check("halt", weld_halt, 1'b1);
      check("dress code", fault_code, `DS_ERR_DRESS);
      rdc(`DS_OFF_CTRL, {16'h0000, `DS_ERR_DRESS}, "code register");
      spots(1);
      recover();
      check("code cleared", fault_code, 16'h0);
      rdc(`DS_OFF_COUNT, 32'h0001_0000, "resume next");
      ack_en <= 1'b0;
      spots(10);
      check("life code", fault_code, `DS_ERR_LIFE);
      recover();
      wr(`DS_OFF_CFG0, CFG0 & 32'hFFFF_FF80);
      spots(10);
      check("off warn", dress_warn, 1'b0);
      check("off halt", weld_halt, 1'b0);
      check("off current", weld_current, BASE);
      conclude();
   end
endmodule
bind electrode_dressing_supervisor electrode_dressing_supervisor_asserts u_chk (.*);
`default_nettype wire
